// [pkg/ubdf_defs.vh]
/*
  Register offsets, field positions, reset values and timing counts for the
  bulk list, completed-descriptor and frame timing register bank.
  Assumes inclusion by bare name from the design files.
*/
`ifndef UBDF_DEFS_VH
`define UBDF_DEFS_VH

`define UBDF_OFS_BULK_HEAD     8'h28
`define UBDF_OFS_BULK_CUR      8'h2c
`define UBDF_OFS_DONE_HEAD     8'h30
`define UBDF_OFS_FRAME_CFG     8'h34
`define UBDF_OFS_FRAME_LEFT    8'h38

`define UBDF_PTR_MSB           31
`define UBDF_PTR_LSB           4
`define UBDF_LEN_MSB           13
`define UBDF_BUDGET_MSB        30
`define UBDF_BUDGET_LSB        16
`define UBDF_TOGGLE_BIT        31

`define UBDF_FRAME_LEN_RST     14'h2edf
`define UBDF_PTR_RST           28'h0000000

// Bit time is 1/12 MHz; the divider approximates it from the system clock.
`define UBDF_BIT_NS            84
`define UBDF_CLK_NS            100

`endif

// [test/ubdf_assertions.sv]
/* Port assertions for the bulk, done and frame register bank.
   Bound from the bench top; one clock, synchronous reset. */
`timescale 1ns/1ps
module ubdf_assertions (
  input wire        i_sys_clk,
  input wire        i_rst,
  input wire        i_reg_wr,
  input wire        i_reg_rd,
  input wire [7:0]  i_reg_addr,
  input wire [31:0] o_reg_rdata,
  input wire        o_reg_ack,
  input wire        i_list_end,
  input wire        i_bulk_list_filled,
  input wire        o_bulk_list_filled_clr,
  input wire        i_td_done,
  input wire [31:0] i_td_addr,
  input wire [31:0] o_td_next_link,
  input wire        o_td_next_link_vld,
  input wire        i_operational_state,
  input wire        o_frame_start,
  input wire [15:0] o_frame_count
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  property p_ack; !$past(i_rst) |->
    o_reg_ack == $past(i_reg_wr | i_reg_rd); endproperty
  a_ack: assert property (p_ack) else $error("ack timing");
  property p_rsvd; o_reg_ack && $past(i_reg_rd) |-> (o_reg_rdata &
    ($past(i_reg_addr) == 8'h34 ? 32'hc000 : $past(i_reg_addr) == 8'h38 ?
    32'h7fffc000 : 32'hf)) == 32'h0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits");
  property p_hold; !$past(i_rst) && !$past(i_reg_rd) |->
    $stable(o_reg_rdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_link; !$past(i_rst) |->
    o_td_next_link_vld == $past(i_td_done); endproperty
  a_link: assert property (p_link) else $error("link strobe");
  property p_chain; i_td_done ##1 i_td_done |=>
    o_td_next_link == ($past(i_td_addr, 2) & 32'hfffffff0); endproperty
  a_chain: assert property (p_chain) else $error("link value");
  property p_clr; !$past(i_rst) |-> o_bulk_list_filled_clr ==
    $past(i_list_end && i_bulk_list_filled); endproperty
  a_clr: assert property (p_clr) else $error("filled clear");
  property p_fcnt; !$past(i_rst) && o_frame_count != $past(o_frame_count)
    |-> o_frame_start && o_frame_count == $past(o_frame_count) + 16'h1;
  endproperty
  a_fcnt: assert property (p_fcnt) else $error("frame count");
  property p_oper; o_frame_start |-> $past(i_operational_state) ||
    $past(i_operational_state, 2); endproperty
  a_oper: assert property (p_oper) else $error("frame while idle");
endmodule

// [test/ubdf_engine_model.sv]
/* List engine stand-in: request pulses, filled flag, descriptor links.
   Assumes go is called 1 ns after a rising edge, from one process. */
`timescale 1ns/1ps
module ubdf_engine_model (
  input  wire        i_sys_clk,
  input  wire        i_filled_clr,
  input  wire [31:0] i_link,
  input  wire        i_link_vld,
  output reg  [4:0]  o_req = 5'h0,
  output reg  [31:0] o_addr = 32'h0,
  output reg         o_filled = 1'b0
);
  reg [31:0] links [$];
  always @(posedge i_sys_clk) begin
    if (i_filled_clr) o_filled <= 1'b0;
    if (i_link_vld) links.push_back(i_link);
  end
  task go(input [4:0] r, input [31:0] ad);
    begin
      o_req = r;
      o_addr = (r == 5'h0) ? ~o_addr : ad;
      @(posedge i_sys_clk);
      #1;
    end
  endtask
endmodule

// [test/usb_host_bulk_done_frame_regs_tb.sv]
/* Bench for ubdf_regs with a register model and an engine stand-in.
   Assumes the checker and engine model are compiled first. */
`timescale 1ns/1ps
module usb_host_bulk_done_frame_regs_tb;
  localparam DIV = 2;
  reg         i_sys_clk = 1'b0, i_rst = 1'b1, i_reg_wr = 1'b0;
  reg         i_reg_rd = 1'b0, i_bulk_list_enable = 1'b0;
  reg         i_operational_state = 1'b0;
  reg  [7:0]  i_reg_addr = 8'h0, a;
  reg  [31:0] i_reg_wdata = 32'h0, d, e, m [0:4];
  wire [31:0] o_reg_rdata, o_td_next_link, o_bulk_current_addr, ea;
  wire        o_reg_ack, o_bulk_list_filled_clr, o_td_next_link_vld;
  wire        o_frame_start, i_bulk_list_filled, i_head_load, i_ed_served;
  wire        i_list_end, i_td_done, i_done_writeback;
  wire [14:0] o_packet_budget_cnt;
  wire [15:0] o_frame_count;
  wire [31:0] i_head_load_addr = ea, i_ed_next_addr = ea, i_td_addr = ea;
  integer     seed = 35, num_errors = 0, cmp_count = 0, n, cyc = 0, fc;
  ubdf_regs #(.BIT_DIV(DIV)) dut (.*);
  ubdf_engine_model eng (
    .i_sys_clk    (i_sys_clk),
    .i_filled_clr (o_bulk_list_filled_clr),
    .i_link       (o_td_next_link),
    .i_link_vld   (o_td_next_link_vld),
    .o_req        ({i_head_load, i_ed_served, i_list_end, i_td_done,
                    i_done_writeback}),
    .o_addr       (ea),
    .o_filled     (i_bulk_list_filled)
  );
  initial forever #50 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      num_errors = num_errors + 1;
      conclude;
    end
  end
  task step;
    begin
      @(posedge i_sys_clk);
      #1;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task acc(input w, input [7:0] ad, input [31:0] wd);
    begin
      i_reg_wr = w;
      i_reg_rd = ~w;
      i_reg_addr = ad;
      i_reg_wdata = wd;
      if (w && ad > 8'h27 && ad < 8'h39 && !(ad == 8'h2c && i_bulk_list_enable))
        m[(ad - 8'h28) >> 2] = wd;
      step;
      chk(o_reg_ack, 32'h1);
    end
  endtask
  task rdc(input [7:0] ad);
    begin
      acc(1'b0, ad, ~i_reg_wdata);
      chk(o_reg_rdata, ad == 8'h34 ? m[3] & 32'hffff3fff : ad == 8'h38 ?
        m[4] & 32'h80003fff : (ad > 8'h27 && ad < 8'h31) ?
        m[(ad - 8'h28) >> 2] & 32'hfffffff0 : 32'h0);
    end
  endtask
  task idle;
    begin
      i_reg_wr = 1'b0;
      i_reg_rd = 1'b0;
      step;
    end
  endtask
  task fwait;
    begin
      n = 0;
      step;
      while (o_frame_start !== 1'b1 && n < 200) begin
        step;
        n = n + 1;
      end
    end
  endtask
  task conclude;
    begin
      $display("compares %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask
  initial begin
    for (n = 0; n < 5; n = n + 1) m[n] = (n == 3) ? 32'h2edf : 32'h0;
    step;
    step;
    i_rst = 1'b0;
    for (a = 8'h28; a < 8'h40; a = a + 8'h4) rdc(a);
    $display("reset test done");
    repeat (2) for (a = 8'h24; a < 8'h40; a = a + 8'h4) begin
      acc(1'b1, a, $random(seed));
      rdc(a);
    end
    i_bulk_list_enable = 1'b1;
    acc(1'b1, 8'h2c, $random(seed));
    rdc(8'h2c);
    i_bulk_list_enable = 1'b0;
    idle;
    $display("access test done");
    d = $random(seed);
    e = $random(seed);
    eng.go(5'h10, d);
    eng.go(5'h08, e);
    m[0] = d;
    m[1] = e;
    eng.go(5'h04, d);
    eng.o_filled = 1'b1;
    eng.go(5'h0c, d);
    m[1] = d;
    eng.go(5'h00, e);
    chk(i_bulk_list_filled, 32'h0);
    rdc(8'h28);
    rdc(8'h2c);
    chk(o_bulk_current_addr, m[1] & 32'hfffffff0);
    idle;
    e = m[2];
    eng.go(5'h02, d);
    eng.go(5'h02, ~d);
    eng.go(5'h00, d);
    chk(eng.links[0], e & 32'hfffffff0);
    chk(eng.links[1], d & 32'hfffffff0);
    m[2] = ~d;
    rdc(8'h30);
    idle;
    eng.go(5'h01, d);
    eng.go(5'h00, d);
    m[2] = 32'h0;
    rdc(8'h30);
    $display("list test done");
    d = $random(seed) & 32'h7fff0000 | 32'h80000004;
    acc(1'b1, 8'h34, d);
    idle;
    i_operational_state = 1'b1;
    fwait;
    fc = o_frame_count;
    fwait;
    chk(n + 1, DIV * 5);
    chk(o_frame_count, fc + 1);
    chk(o_packet_budget_cnt, d[30:16]);
    acc(1'b0, 8'h38, d);
    chk(o_reg_rdata & 32'hffffc000, 32'h80000000);
    acc(1'b1, 8'h34, 32'h6);
    idle;
    fwait;
    fwait;
    chk(n + 1, DIV * 7);
    acc(1'b0, 8'h38, d);
    chk(o_reg_rdata[31], 32'h0);
    i_operational_state = 1'b0;
    idle;
    acc(1'b1, 8'h38, 32'h3000);
    idle;
    i_operational_state = 1'b1;
    idle;
    idle;
    acc(1'b0, 8'h38, d);
    chk(o_reg_rdata[13:0] < 14'd7 && o_reg_rdata[13:0] > 14'd3, 32'h1);
    $display("frame test done");
    acc(1'b0, 8'h34, d);
    e = o_reg_rdata;
    i_operational_state = 1'b0;
    i_reg_rd = 1'b0;
    i_rst = 1'b1;
    step;
    step;
    i_rst = 1'b0;
    m[3] = 32'h2edf;
    rdc(8'h34);
    m[3] = e ^ 32'h80000000;
    acc(1'b1, 8'h34, m[3]);
    rdc(8'h34);
    $display("restore test done");
    conclude;
  end
endmodule
bind ubdf_regs ubdf_assertions u_chk (.*);

// [verilog/ubdf_bit_tick.v]
/*
  Bit-time enable divider: one-cycle pulse every DIV clock cycles.
  Assumes a single system clock and synchronous active-high reset.
*/
`timescale 1ns/1ps
module ubdf_bit_tick #(
  parameter DIV = 1
) (
  input  wire i_sys_clk,
  input  wire i_rst,
  input  wire i_run,
  output reg  o_tick
);
  reg [15:0] cnt_reg;

  always @(posedge i_sys_clk) begin
    if (i_rst || !i_run) begin
      cnt_reg <= 16'h0000;
      o_tick  <= 1'b0;
    end else if (cnt_reg == DIV[15:0] - 16'h0001) begin
      cnt_reg <= 16'h0000;
      o_tick  <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 16'h0001;
      o_tick  <= 1'b0;
    end
  end
endmodule

// [verilog/ubdf_regs.v]
/*
  Bulk list pointers, completed-descriptor head and frame timing registers.
  Assumes a simple synchronous register port from the driver side and a
  list engine that pulses its requests for one cycle.
*/
// Operation
// - Bulk traversal starts at the bulk head pointer, loaded at initialisation.
// - Bulk endpoints are served round-robin in insertion order.
// - After serving, current pointer advances; next frame resumes from it.
// - At list end, if filled flag set copy head to current, clear flag.
// - Current pointer resets to zero, meaning end of list.
// - Pointer fields are bits 31..4; bits 3..0 reserved, written zero.
// - On completion, old done head goes out as next link, then replaced.
// - Writing done head to shared area clears the done head to zero.
// - Frame length field bits 13..0 resets to 11999 bit times.
// - Largest packet budget loads into its counter at every frame start.
// - Bits-left counter decrements per bit time, reloads after zero.
// - At zero, interval toggle is copied into the remaining toggle.
// - Entering operational state reloads the bits-left counter.
// - Registers at 28h, 2Ch, 30h, 34h, 38h, 32 bits, read/write.
// - Each bits-left reload at zero increments the 16-bit frame count, wrapping.
`timescale 1ns/1ps
`include "ubdf_defs.vh"
module ubdf_regs #(
  parameter BIT_DIV = 1
) (
  input  wire        i_sys_clk,
  input  wire        i_rst,
  input  wire        i_reg_wr,
  input  wire        i_reg_rd,
  input  wire [7:0]  i_reg_addr,
  input  wire [31:0] i_reg_wdata,
  output reg  [31:0] o_reg_rdata,
  output reg         o_reg_ack,
  input  wire        i_bulk_list_enable,
  input  wire        i_operational_state,
  input  wire        i_bulk_list_filled,
  output reg         o_bulk_list_filled_clr,
  input  wire        i_head_load,
  input  wire [31:0] i_head_load_addr,
  input  wire        i_ed_served,
  input  wire [31:0] i_ed_next_addr,
  input  wire        i_list_end,
  input  wire        i_td_done,
  input  wire [31:0] i_td_addr,
  input  wire        i_done_writeback,
  output reg  [31:0] o_td_next_link,
  output reg         o_td_next_link_vld,
  output reg  [31:0] o_bulk_current_addr,
  output reg  [14:0] o_packet_budget_cnt,
  output reg         o_frame_start,
  output reg  [15:0] o_frame_count
);

  //////////////////////////////////////////////////////////////////////////
  reg [27:0] bulk_head_addr_reg;
  reg [27:0] bulk_current_addr_reg;
  reg [27:0] completed_list_head_addr_reg;
  reg        interval_toggle_reg;
  reg [14:0] largest_packet_budget_reg;
  reg [13:0] frame_length_reg;
  reg        remaining_toggle_reg;
  reg [13:0] bits_left_count_reg;
  reg        oper_d_reg;
  wire       bit_tick;
  wire       oper_rise;
  wire       wr_cur_ok;
  wire       cnt_zero;
  wire       reload;

  // Pointer view of a register: reserved low nibble always reads zero.
  function [31:0] ubdf_ptr;
    input [27:0] p;
    begin
      ubdf_ptr = {p, 4'h0};
    end
  endfunction

  function sel;
    input [7:0] a;
    input [7:0] ofs;
    begin
      sel = (a == ofs);
    end
  endfunction

  ubdf_bit_tick #(.DIV(BIT_DIV)) u_tick (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_run     (i_operational_state),
    .o_tick    (bit_tick)
  );

  assign oper_rise = i_operational_state & ~oper_d_reg;
  assign cnt_zero  = (bits_left_count_reg == 14'h0000);
  assign reload    = bit_tick & cnt_zero;
  assign wr_cur_ok = i_reg_wr & sel(i_reg_addr, `UBDF_OFS_BULK_CUR)
                     & ~i_bulk_list_enable;

  //////////////////////////////////////////////////////////////////////////
  // Bulk list pointers.
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      bulk_head_addr_reg     <= `UBDF_PTR_RST;
      bulk_current_addr_reg  <= `UBDF_PTR_RST;
      o_bulk_list_filled_clr <= 1'b0;
    end else begin
      o_bulk_list_filled_clr <= 1'b0;
      if (i_head_load)
        bulk_head_addr_reg <= i_head_load_addr[31:4];
      else if (i_reg_wr && sel(i_reg_addr, `UBDF_OFS_BULK_HEAD))
        bulk_head_addr_reg <= i_reg_wdata[31:4];
      if (i_list_end) begin
        if (i_bulk_list_filled) begin
          bulk_current_addr_reg  <= bulk_head_addr_reg;
          o_bulk_list_filled_clr <= 1'b1;
        end
      end else if (i_ed_served) begin
        bulk_current_addr_reg <= i_ed_next_addr[31:4];
      end else if (wr_cur_ok) begin
        bulk_current_addr_reg <= i_reg_wdata[31:4];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Completed descriptor queue head. A completion in the writeback cycle
  // wins, so no finished descriptor is dropped from the queue.
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      completed_list_head_addr_reg <= `UBDF_PTR_RST;
      o_td_next_link               <= 32'h00000000;
      o_td_next_link_vld           <= 1'b0;
    end else begin
      o_td_next_link_vld <= 1'b0;
      if (i_td_done) begin
        o_td_next_link     <= ubdf_ptr(completed_list_head_addr_reg);
        o_td_next_link_vld <= 1'b1;
        completed_list_head_addr_reg <= i_td_addr[31:4];
      end else if (i_done_writeback) begin
        completed_list_head_addr_reg <= `UBDF_PTR_RST;
      end else if (i_reg_wr && sel(i_reg_addr, `UBDF_OFS_DONE_HEAD)) begin
        completed_list_head_addr_reg <= i_reg_wdata[31:4];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Frame interval configuration and bits-left counter.
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      interval_toggle_reg       <= 1'b0;
      largest_packet_budget_reg <= 15'h0000;
      frame_length_reg          <= `UBDF_FRAME_LEN_RST;
      remaining_toggle_reg      <= 1'b0;
      bits_left_count_reg       <= 14'h0000;
      oper_d_reg                <= 1'b0;
      o_packet_budget_cnt       <= 15'h0000;
      o_frame_start             <= 1'b0;
      o_frame_count             <= 16'h0000;
    end else begin
      oper_d_reg    <= i_operational_state;
      o_frame_start <= 1'b0;
      if (i_reg_wr && sel(i_reg_addr, `UBDF_OFS_FRAME_CFG)) begin
        interval_toggle_reg <= i_reg_wdata[`UBDF_TOGGLE_BIT];
        largest_packet_budget_reg <=
          i_reg_wdata[`UBDF_BUDGET_MSB:`UBDF_BUDGET_LSB];
        frame_length_reg <= i_reg_wdata[`UBDF_LEN_MSB:0];
      end
      if (oper_rise) begin
        bits_left_count_reg <= frame_length_reg;
      end else if (reload) begin
        bits_left_count_reg  <= frame_length_reg;
        remaining_toggle_reg <= interval_toggle_reg;
        o_frame_count        <= o_frame_count + 16'h0001;
        o_packet_budget_cnt  <= largest_packet_budget_reg;
        o_frame_start        <= 1'b1;
      end else if (bit_tick) begin
        bits_left_count_reg <= bits_left_count_reg - 14'h0001;
      end else if (i_reg_wr && sel(i_reg_addr, `UBDF_OFS_FRAME_LEFT)) begin
        remaining_toggle_reg <= i_reg_wdata[`UBDF_TOGGLE_BIT];
        bits_left_count_reg  <= i_reg_wdata[`UBDF_LEN_MSB:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read port; unmapped offsets return zero.
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_reg_rdata         <= 32'h00000000;
      o_reg_ack           <= 1'b0;
      o_bulk_current_addr <= 32'h00000000;
    end else begin
      o_reg_ack           <= i_reg_rd | i_reg_wr;
      o_bulk_current_addr <= ubdf_ptr(bulk_current_addr_reg);
      if (i_reg_rd) begin
        case (i_reg_addr)
          `UBDF_OFS_BULK_HEAD:
            o_reg_rdata <= ubdf_ptr(bulk_head_addr_reg);
          `UBDF_OFS_BULK_CUR:
            o_reg_rdata <= ubdf_ptr(bulk_current_addr_reg);
          `UBDF_OFS_DONE_HEAD:
            o_reg_rdata <= ubdf_ptr(completed_list_head_addr_reg);
          `UBDF_OFS_FRAME_CFG:
            o_reg_rdata <= {interval_toggle_reg, largest_packet_budget_reg,
                            2'b00, frame_length_reg};
          `UBDF_OFS_FRAME_LEFT:
            o_reg_rdata <= {remaining_toggle_reg, 17'h00000,
                            bits_left_count_reg};
          default:
            o_reg_rdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule
